// ==== switch_monitor_config_checker.sv ====
// apb-reached checker of a switch monitor's configuration image
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`include "smcc_defines.svh"
module switch_monitor_config_checker import smcc_pkg::*; #(
    parameter int TH_W = 10,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic check_busy_o,
    output logic check_done_o,
    output logic check_pass_o
);
    localparam int NPAIR = 7;
    localparam int NWET = 3;
    // threshold slot pairs that must satisfy upper >= lower
    localparam int HI_SLOT [NPAIR] = '{`SMCC_T_L2_HI, `SMCC_T_L3_B,
        `SMCC_T_L3_C, `SMCC_T_EIGHT, `SMCC_T_NINE, `SMCC_T_S0_HI,
        `SMCC_T_S1_HI};
    localparam int LO_SLOT [NPAIR] = '{`SMCC_T_L2_LO, `SMCC_T_L3_A,
        `SMCC_T_L3_B, `SMCC_T_L3_C, `SMCC_T_EIGHT, `SMCC_T_S0_LO,
        `SMCC_T_S1_LO};
    // wetting pairs: sink lsb in word, sink word, source lsb in word a
    localparam int SINK_LSB [NWET] = '{18, 21, 0};
    localparam int SINK_WORD [NWET] = '{`SMCC_C_WC_A, `SMCC_C_WC_A,
        `SMCC_C_WC_B};
    localparam int SRC_LSB [NWET] = '{6, 9, 12};

    if (TH_W < 1 || TH_W > 16) begin : g_bad_thw
        $error("threshold width must fit a half word");
    end
    if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_aw
        $error("address width must be 6 to 8 bits");
    end
    // the map constants feed the decode below; catch a bad edit early
    if (`SMCC_NUM_THR > 2 * `SMCC_THR_WORDS) begin : g_bad_thr
        $error("more threshold slots than threshold words hold");
    end
    if (`SMCC_CFG_W > 32) begin : g_bad_cfg
        $error("image word wider than the data bus");
    end
    if (`SMCC_ST_VIOL_W > `SMCC_ST_DONE) begin : g_bad_st
        $error("violation field runs into the status flags");
    end
    if (`SMCC_V_UNSUP + 1 != `SMCC_ST_VIOL_W) begin : g_bad_viol
        $error("violation bits and status field width disagree");
    end
    if (`SMCC_ST_MTX_LSB + 2 > 32) begin : g_bad_mtx
        $error("matrix field falls off the status word");
    end

    chk_state_t state_q;
    chk_state_t state_d;
    logic [TH_W-1:0] thr_q [`SMCC_NUM_THR];
    logic [`SMCC_CFG_W-1:0] cfg_q [`SMCC_CFG_WORDS];
    logic tw_q;
    logic poll_en_q;
    logic [`SMCC_ST_VIOL_W-1:0] viol_q;
    logic done_q;
    logic pass_q;
    logic [31:0] prdata_q;

    logic [7:0] addr8;
    logic [5:0] widx;
    logic aligned;
    logic hit_ctrl;
    logic hit_thr;
    logic hit_cfg;
    logic hit_status;
    logic mapped;
    logic setup;
    logic access;
    logic wr_en;
    logic start;
    logic busy;
    logic [5:0] thr_word;
    logic [5:0] cfg_word;

    logic [NPAIR-1:0] ge;
    logic [NWET-1:0] wet_gt;
    logic [NWET-1:0] tw_bad;
    logic [4:0] thr_viol;
    logic [6:0] mtx_viol;
    matrix_mode_t mtx_mode;
    logic is_4x4;
    logic [3:0] en_sink;
    logic [3:0] en_src;
    logic [3:0] md_sink;
    logic [3:0] md_src;
    logic [3:0] cs_sink;
    logic [3:0] cs_src;

    // address decode; any unaligned or unlisted word is an error
    assign addr8 = 8'(paddr_i);
    assign widx = addr8[7:2];
    assign aligned = (addr8[1:0] == 2'b00);
    assign thr_word = widx - 6'(`SMCC_OFS_THR0 >> 2);
    assign cfg_word = widx - 6'(`SMCC_OFS_CFG0 >> 2);
    assign hit_ctrl = aligned && (addr8 == `SMCC_OFS_CTRL);
    assign hit_thr = aligned && (widx >= 6'(`SMCC_OFS_THR0 >> 2))
        && (thr_word < 6'(`SMCC_THR_WORDS));
    assign hit_cfg = aligned && (widx >= 6'(`SMCC_OFS_CFG0 >> 2))
        && (cfg_word < 6'(`SMCC_CFG_WORDS));
    assign hit_status = aligned && (addr8 == `SMCC_OFS_STATUS);
    assign mapped = hit_ctrl || hit_thr || hit_cfg || hit_status;

    // zero-wait slave: the access phase always completes at once
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    assign pready_o = 1'b1;
    assign pslverr_o = access && !mapped;
    assign wr_en = access && pwrite_i && mapped;
    assign busy = (state_q != S_IDLE);
    // start while a check runs is ignored, not queued
    assign start = wr_en && hit_ctrl && pwdata_i[`SMCC_CTRL_START] && !busy;

    // control bits; image writes are frozen while busy so a check
    // never sees a half-updated configuration
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tw_q <= 1'b0;
            poll_en_q <= 1'b0;
        end else if (wr_en && hit_ctrl && !busy) begin
            tw_q <= pwdata_i[`SMCC_CTRL_TW];
            poll_en_q <= pwdata_i[`SMCC_CTRL_POLL];
        end
    end

    // threshold slots, two per word
    for (genvar t = 0; t < `SMCC_NUM_THR; t++) begin : g_thr
        localparam int LSB = (t % 2) * `SMCC_THR_HI_POS;
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                thr_q[t] <= '0;
            end else if (wr_en && hit_thr && !busy
                         && (thr_word == 6'(t / 2))) begin
                thr_q[t] <= pwdata_i[LSB +: TH_W];
            end
        end
    end

    // device configuration image words
    for (genvar c = 0; c < `SMCC_CFG_WORDS; c++) begin : g_cfg
        always_ff @(posedge clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                cfg_q[c] <= `SMCC_RST_CFG;
            end else if (wr_en && hit_cfg && !busy
                         && (cfg_word == 6'(c))) begin
                cfg_q[c] <= pwdata_i[`SMCC_CFG_W-1:0];
            end
        end
    end

    // threshold ordering comparators
    for (genvar p = 0; p < NPAIR; p++) begin : g_ord
        order_check #(
            .W(TH_W)
        ) u_ord (
            .upper_i(thr_q[HI_SLOT[p]]),
            .lower_i(thr_q[LO_SLOT[p]]),
            .ge_o(ge[p]),
            .gt_o()
        );
    end

    // wetting code pairs, sink against source, plus thermal limits
    for (genvar w = 0; w < NWET; w++) begin : g_wet
        logic [2:0] sink_code;
        logic [2:0] src_code;
        assign sink_code = cfg_q[SINK_WORD[w]][SINK_LSB[w] +: 3];
        assign src_code = cfg_q[`SMCC_C_WC_A][SRC_LSB[w] +: 3];
        order_check #(
            .W(3)
        ) u_wet (
            .upper_i(sink_code),
            .lower_i(src_code),
            .ge_o(),
            .gt_o(wet_gt[w])
        );
        // source limited to codes 1 and 2
        // source 2 needs sink exactly 3, source 1 sink 2 or above
        always_comb begin
            unique case (src_code)
                3'h1: begin
                    tw_bad[w] = (sink_code < 3'h2);
                end
                3'h2: begin
                    tw_bad[w] = (sink_code != 3'h3);
                end
                // 0 ma and the high currents are all barred
                default: begin
                    tw_bad[w] = 1'b1;
                end
            endcase
        end
    end

    // threshold verdicts, the same in every operating mode
    assign thr_viol[0] = !ge[0];
    assign thr_viol[1] = !(ge[1] && ge[2]);
    assign thr_viol[2] = !(ge[3] && ge[4]);
    assign thr_viol[3] = !ge[5];
    assign thr_viol[4] = !ge[6];

    // matrix field decode
    assign mtx_mode = matrix_mode_t'(cfg_q[`SMCC_C_MATRIX]
        [`SMCC_MATRIX_LSB +: 2]);
    assign is_4x4 = (mtx_mode == MTX_4X4);

    // per-group slices of the matrix inputs
    assign en_sink = cfg_q[`SMCC_C_IN_EN][`SMCC_SINK_LSB +: 4];
    assign en_src = cfg_q[`SMCC_C_IN_EN][`SMCC_SRC_LSB +: 4];
    assign md_sink = cfg_q[`SMCC_C_MODE][`SMCC_SINK_LSB +: 4];
    assign md_src = cfg_q[`SMCC_C_MODE][`SMCC_SRC_LSB +: 4];
    assign cs_sink = cfg_q[`SMCC_C_CS_SEL][`SMCC_SINK_LSB +: 4];
    assign cs_src = cfg_q[`SMCC_C_CS_SEL][`SMCC_SRC_LSB +: 4];

    // 4x4 demands; larger matrices are only flagged as unchecked
    assign mtx_viol[0] = is_4x4 && !poll_en_q;
    assign mtx_viol[1] = is_4x4 && ((en_sink != `SMCC_GRP_ONES)
        || (en_src != `SMCC_GRP_ONES));
    // a set mode bit would put the input on the adc
    assign mtx_viol[2] = is_4x4 && ((md_sink != `SMCC_GRP_ZERO)
        || (md_src != `SMCC_GRP_ZERO));
    assign mtx_viol[3] = is_4x4 && ((cs_sink != `SMCC_GRP_ONES)
        || (cs_src != `SMCC_GRP_ZERO));
    assign mtx_viol[4] = is_4x4 && !(&wet_gt);
    assign mtx_viol[5] = is_4x4 && tw_q && (|tw_bad);
    assign mtx_viol[6] = (mtx_mode == MTX_5X5) || (mtx_mode == MTX_6X6);

    // check sequencer: thresholds, then matrix, then verdict
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE: begin
                if (start) begin
                    state_d = S_THRESH;
                end
            end
            S_THRESH: begin
                state_d = S_MATRIX;
            end
            S_MATRIX: begin
                state_d = S_DONE;
            end
            S_DONE: begin
                state_d = S_IDLE;
            end
            // a corrupted one-hot code falls back to idle
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= S_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // violation capture, cleared by each new start
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            viol_q <= '0;
        end else if (start) begin
            viol_q <= '0;
        end else if (state_q == S_THRESH) begin
            viol_q[`SMCC_V_S1:`SMCC_V_L2] <= thr_viol;
        end else if (state_q == S_MATRIX) begin
            viol_q[`SMCC_V_UNSUP:`SMCC_V_POLL] <= mtx_viol;
        end
    end

    // done flag; start cannot coincide with the set, busy blocks it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_q <= 1'b0;
        end else if (state_q == S_DONE) begin
            done_q <= 1'b1;
        end else if (start) begin
            done_q <= 1'b0;
        end
    end

    // pass verdict; stands with done until the next start
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pass_q <= 1'b0;
        end else if (state_q == S_DONE) begin
            pass_q <= ~|viol_q;
        end else if (start) begin
            pass_q <= 1'b0;
        end
    end

    // read data registered in the setup cycle, valid in access phase
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_q <= `SMCC_RST_WORD;
        end else if (setup && !pwrite_i) begin
            prdata_q <= `SMCC_RST_WORD;
            if (hit_ctrl) begin
                prdata_q[`SMCC_CTRL_TW] <= tw_q;
                prdata_q[`SMCC_CTRL_POLL] <= poll_en_q;
            end else if (hit_thr) begin
                for (int t = 0; t < `SMCC_NUM_THR; t++) begin
                    if (thr_word == 6'(t / 2)) begin
                        prdata_q[(t % 2) * `SMCC_THR_HI_POS +: TH_W]
                            <= thr_q[t];
                    end
                end
            end else if (hit_cfg) begin
                for (int c = 0; c < `SMCC_CFG_WORDS; c++) begin
                    if (cfg_word == 6'(c)) begin
                        prdata_q[`SMCC_CFG_W-1:0] <= cfg_q[c];
                    end
                end
            end else if (hit_status) begin
                prdata_q[`SMCC_ST_VIOL_W-1:0] <= viol_q;
                prdata_q[`SMCC_ST_DONE] <= done_q;
                prdata_q[`SMCC_ST_BUSY] <= busy;
                prdata_q[`SMCC_ST_PASS] <= pass_q;
                prdata_q[`SMCC_ST_MTX_LSB +: 2] <= mtx_mode;
            end
        end
    end

    assign prdata_o = prdata_q;
    assign check_busy_o = busy;
    assign check_done_o = done_q;
    assign check_pass_o = pass_q;
endmodule : switch_monitor_config_checker

// ==== smcc_defines.svh ====
// register offsets, field positions, reset values for the config checker
// Overview of operation
// - level2 high threshold not below level2 low
// - level3 thresholds third >= second >= first
// - ninth >= eighth >= level3 third chain
// - threshold order checked in every mode
// - each supply set high threshold not below low
// - matrix field bits 4:3 equal 01 selects 4x4
// - 4x4: polling on, inputs 7:4 13:10 enabled
// - 4x4: matrix inputs in comparator mode
// - 4x4: 7:4 sinks, 13:10 sources
// - 4x4: sink wetting code above paired source
// - 4x4 thermal warning: sources only 1 or 2 mA
// - source 001 any sink 010+, 010 needs 011
`ifndef SMCC_DEFINES_SVH
`define SMCC_DEFINES_SVH

// byte offsets of the controller's own registers
`define SMCC_OFS_CTRL 8'h00
`define SMCC_OFS_THR0 8'h04
`define SMCC_OFS_CFG0 8'h1c
`define SMCC_OFS_STATUS 8'h34
`define SMCC_THR_WORDS 6
`define SMCC_NUM_THR 11
`define SMCC_CFG_WORDS 6

// control register fields
`define SMCC_CTRL_START 0
`define SMCC_CTRL_TW 1
`define SMCC_CTRL_POLL 2

// threshold slots, two per word: even slot low half, odd slot high half
`define SMCC_THR_HI_POS 16
`define SMCC_T_L2_LO 0
`define SMCC_T_L2_HI 1
`define SMCC_T_L3_A 2
`define SMCC_T_L3_B 3
`define SMCC_T_L3_C 4
`define SMCC_T_EIGHT 5
`define SMCC_T_NINE 6
`define SMCC_T_S0_LO 7
`define SMCC_T_S0_HI 8
`define SMCC_T_S1_LO 9
`define SMCC_T_S1_HI 10

// device configuration image slots
`define SMCC_C_MATRIX 0
`define SMCC_C_IN_EN 1
`define SMCC_C_MODE 2
`define SMCC_C_CS_SEL 3
`define SMCC_C_WC_A 4
`define SMCC_C_WC_B 5
`define SMCC_CFG_W 24

// device field positions
`define SMCC_MATRIX_LSB 3
`define SMCC_MATRIX_4X4 2'b01
`define SMCC_SINK_LSB 4
`define SMCC_SRC_LSB 10
`define SMCC_GRP_ONES 4'hf
`define SMCC_GRP_ZERO 4'h0

// status register fields
`define SMCC_ST_VIOL_W 12
`define SMCC_ST_DONE 16
`define SMCC_ST_BUSY 17
`define SMCC_ST_PASS 18
`define SMCC_ST_MTX_LSB 19

// violation bit indices
`define SMCC_V_L2 0
`define SMCC_V_L3 1
`define SMCC_V_IN23 2
`define SMCC_V_S0 3
`define SMCC_V_S1 4
`define SMCC_V_POLL 5
`define SMCC_V_IN_EN 6
`define SMCC_V_MODE 7
`define SMCC_V_CS 8
`define SMCC_V_WET 9
`define SMCC_V_TW 10
`define SMCC_V_UNSUP 11

// reset values
`define SMCC_RST_WORD 32'h0000_0000
`define SMCC_RST_CFG 24'h00_0000

`endif

// ==== smcc_pkg.sv ====
// types shared by the configuration checker
package smcc_pkg;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_THRESH = 4'b0010,
        S_MATRIX = 4'b0100,
        S_DONE = 4'b1000
    } chk_state_t;

    typedef enum logic [1:0] {
        MTX_NONE = 2'b00,
        MTX_4X4 = 2'b01,
        MTX_5X5 = 2'b10,
        MTX_6X6 = 2'b11
    } matrix_mode_t;
endpackage : smcc_pkg

// ==== order_check.sv ====
// unsigned magnitude compare of one threshold or code pair
`timescale 1ns/100ps
module order_check #(
    parameter int W = 10
) (
    input wire logic [W-1:0] upper_i,
    input wire logic [W-1:0] lower_i,
    output logic ge_o,
    output logic gt_o
);
    if (W < 1) begin : g_bad_w
        $error("order_check: width must be at least one");
    end

    // plain compares; no sign, codes and thresholds are unsigned
    assign ge_o = (upper_i >= lower_i);
    assign gt_o = (upper_i > lower_i);
endmodule : order_check

// ==== switch_monitor_config_checker_chk.sv ====
// concurrent checks on the config checker's apb and check ports
`timescale 1ns/100ps
module switch_monitor_config_checker_chk #(
    parameter int TH_W = 10,
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic check_busy_o,
    input wire logic check_done_o,
    input wire logic check_pass_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // a start only counts while idle; one seen while busy is dropped
    wire logic acc = psel_i && penable_i;
    wire logic start = acc && pwrite_i && paddr_i == 8'h00 && pwdata_i[0]
        && !check_busy_o;
    sequence run_s;
        (check_busy_o && !check_done_o && !check_pass_o) [*3];
    endsequence
    sequence end_s;
        check_done_o && !check_busy_o;
    endsequence
    // done may land one edge late, but busy has to bridge that edge
    start_run_a: assert property (start |=> run_s ##1 (end_s or
        (check_busy_o ##1 end_s))) else $error("check sequence broken");
    ready_a: assert property (pready_o) else $error("pready low");
    err_phase_a: assert property (pslverr_o |-> acc)
        else $error("error outside access");
    unalign_a: assert property (acc && paddr_i[1:0] != 2'b00 |-> pslverr_o)
        else $error("unaligned access accepted");
    hole_a: assert property (acc && paddr_i > 8'h34 |-> pslverr_o &&
        (pwrite_i || prdata_o == 32'h0)) else $error("hole access accepted");
    mapped_a: assert property (acc && paddr_i <= 8'h34 &&
        paddr_i[1:0] == 2'b00 |-> !pslverr_o)
        else $error("mapped access refused");
    pass_done_a: assert property (check_pass_o |-> check_done_o)
        else $error("pass without done");
    result_hold_a: assert property (!start && !check_busy_o |=>
        $stable(check_done_o) && $stable(check_pass_o))
        else $error("result changed while idle");
    busy_cause_a: assert property ($rose(check_busy_o) |-> $past(start))
        else $error("busy without start");
    start_c: cover property (start);
endmodule : switch_monitor_config_checker_chk

// ==== cfg_image_model.sv ====
// legal 4x4 device image as host software programs it
`timescale 1ns/100ps
module cfg_image_model (
    output logic [23:0] matrix_o,
    output logic [23:0] in_en_o,
    output logic [23:0] mode_o,
    output logic [23:0] cs_sel_o,
    output logic [23:0] wc_a_o,
    output logic [23:0] wc_b_o
);
    // field 4:3 = 01 picks 4x4; 00 none, 10 5x5, 11 6x6
    assign matrix_o = 24'h00_0008;
    // both matrix groups enabled
    assign in_en_o = 24'h00_3cf0;
    // mode 0 keeps comparator sensing, 1 would mean adc
    assign mode_o = 24'h00_0000;
    // 7:4 sink, 13:10 source
    assign cs_sel_o = 24'h00_00f0;
    // sinks 3,2,3 over sources 1,1,2; sources stay at 1 or 2 ma so a
    // thermal warning needs no reprogramming, source 2 pairs with sink 3
    assign wc_a_o = 24'h4c_2240;
    assign wc_b_o = 24'h00_0003;
endmodule : cfg_image_model

// ==== test_switch_monitor_config_checker.sv ====
// self-checking bench for the switch monitor config checker
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module test_switch_monitor_config_checker;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, check_busy_o, check_done_o, check_pass_o;
    logic [23:0] img [6];
    logic [33:0] exp_q [$];
    logic [33:0] e;
    logic [9:0] v;
    logic [31:0] thw;
    int fails = 0;
    int tests_run = 0;
    int cyc = 0;
    integer seed = 32'h12d23f01;

    switch_monitor_config_checker #(.TH_W(10), .ADDR_W(8))
    i_switch_monitor_config_checker (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .check_busy_o(check_busy_o),
        .check_done_o(check_done_o), .check_pass_o(check_pass_o));
    cfg_image_model i_cfg_image_model (
        .matrix_o(img[0]), .in_en_o(img[1]), .mode_o(img[2]),
        .cs_sel_o(img[3]), .wc_a_o(img[4]), .wc_b_o(img[5]));

    always #20 clk_i = ~clk_i;

    // hang guard, the full run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            finish_test();
        end
    end

    // each completed access takes the oldest note: {read, err, data}
    always @(posedge clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(pslverr_o, e[32])
            if (e[33]) `CHK(prdata_o, e[31:0])
        end
    end

    task automatic finish_test();
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test

    // called right after an edge; leaves the bus held at the pready edge
    task automatic xfer(input logic w, input logic [7:0] a,
            input logic [31:0] d, input logic [31:0] ed, input logic ee);
        exp_q.push_back({~w, ee, ed});
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do @(posedge clk_i); while (pready_o !== 1'b1);
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b0, a, 32'h0, d, 1'b0);
    endtask : rd

    task automatic wait_done();
        int n;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (check_done_o !== 1'b1 && n < 20);
    endtask : wait_done

    function automatic logic [31:0] w(input logic [9:0] h, l);
        return {6'h0, h, 6'h0, l};
    endfunction : w

    function automatic logic [31:0] st(input logic [11:0] vl,
            input logic [1:0] m);
        return {11'h0, m, vl == 12'h0, 1'b0, 1'b1, 4'h0, vl};
    endfunction : st

    // spoil one word, run a check, compare status, then restore the word
    task automatic cs(input logic [7:0] a, input logic [31:0] bad,
            input logic [2:0] c, input logic [11:0] vl, input logic [1:0] m);
        wr(a, bad);
        wr(8'h00, {29'h0, c});
        wait_done();
        `CHK(check_done_o, 1'b1)
        `CHK(check_busy_o, 1'b0)
        `CHK(check_pass_o, vl == 12'h0)
        rd(8'h34, st(vl, m));
        wr(a, a < 8'h1c ? thw : {8'h0, img[(a - 8'h1c) >> 2]});
    endtask : cs

    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        // mapped words reset to zero, holes and unaligned addresses refuse
        for (int a = 0; a <= 'h34; a += 4) rd(8'(a), 32'h0);
        xfer(1'b0, 8'h38, 32'h0, 32'h0, 1'b1);
        xfer(1'b0, 8'h06, 32'h0, 32'h0, 1'b1);
        xfer(1'b1, 8'hfc, 32'h1, 32'h0, 1'b1);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h00ff_ffff);
        wr(8'h04, 32'hffff_ffff);
        rd(8'h04, 32'h03ff_03ff);
        // equal thresholds sit on the boundary of every ordering check
        repeat (2) begin
            v = 10'($random(seed) & 32'h1fe) + 10'h1;
            thw = w(v, v);
            for (int i = 0; i < 6; i++) wr(8'(8'h04 + 4 * i), thw);
            for (int i = 0; i < 6; i++) wr(8'(8'h1c + 4 * i), {8'h0, img[i]});
            cs(8'h04, thw, 3'h5, 12'h000, 2'h1);
            cs(8'h04, thw, 3'h7, 12'h000, 2'h1);
            cs(8'h04, w(v, v + 10'h1), 3'h5, 12'h001, 2'h1);
            cs(8'h08, w(v - 10'h1, v), 3'h5, 12'h002, 2'h1);
            cs(8'h0c, w(v - 10'h1, v), 3'h5, 12'h004, 2'h1);
            cs(8'h10, w(v + 10'h1, v), 3'h5, 12'h008, 2'h1);
            cs(8'h18, w(v, v - 10'h1), 3'h5, 12'h010, 2'h1);
            cs(8'h04, thw, 3'h1, 12'h020, 2'h1);
            cs(8'h20, {8'h0, img[1] ^ 24'h400}, 3'h5, 12'h040, 2'h1);
            cs(8'h24, {8'h0, img[2] ^ 24'h10}, 3'h5, 12'h080, 2'h1);
            cs(8'h28, {8'h0, img[3] ^ 24'h2000}, 3'h5, 12'h100, 2'h1);
            cs(8'h30, 32'h2, 3'h5, 12'h200, 2'h1);
            cs(8'h30, 32'h4, 3'h7, 12'h400, 2'h1);
            cs(8'h2c, {8'h0, img[4] ^ 24'h18_0080}, 3'h7, 12'h400,
                2'h1);
            cs(8'h1c, 32'h10, 3'h5, 12'h800, 2'h2);
            cs(8'h1c, 32'h18, 3'h5, 12'h800, 2'h3);
            wr(8'h1c, 32'h0);
            cs(8'h04, w(v, v + 10'h1), 3'h1, 12'h001, 2'h0);
            wr(8'h1c, {8'h0, img[0]});
        end
        // an image write landing mid-check is dropped
        wr(8'h00, 32'h5);
        wr(8'h1c, 32'h0);
        // still busy here, matrix field unchanged, no verdict yet
        rd(8'h34, 32'h000a_0000);
        wait_done();
        rd(8'h1c, {8'h0, img[0]});
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        rst_b_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(8'h34, 32'h0);
        rd(8'h1c, 32'h0);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        finish_test();
    end
endmodule : test_switch_monitor_config_checker

bind switch_monitor_config_checker switch_monitor_config_checker_chk #(
    .TH_W(TH_W), .ADDR_W(ADDR_W)) i_switch_monitor_config_checker_chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .check_busy_o(check_busy_o),
    .check_done_o(check_done_o), .check_pass_o(check_pass_o));
